// ===== hw/loader_params.svh
// Offsets, masks, slot indices and expected marker values for the loader.
// Included by the package; holds definitions only.
`ifndef LOADER_PARAMS_SVH
`define LOADER_PARAMS_SVH

// ==========================================================================
// Serial ROM walk
`define ROM_FIRST          8'h14
`define ROM_LAST           8'h2C
`define ROM_ROUTE3         8'h14
`define ROM_RETRY          8'h15
`define ROM_CARD           8'h16
`define ROM_DEVCTL         8'h17
`define ROM_DIAG           8'h18
`define ROM_SOCK           8'h1C
`define ROM_OHCI_IND       8'h22
`define ROM_OHCI_CNT       8'h23
`define ROM_LATGNT         8'h24
`define ROM_SVID0          8'h25
`define ROM_SVID1          8'h26
`define ROM_SSID0          8'h27
`define ROM_SSID1          8'h28
`define ROM_LINK           8'h29
`define ROM_MINIROM        8'h2A
`define ROM_UID0           8'h2B
`define ROM_UID1           8'h2C

// ==========================================================================
// Target bit masks and expected marker bytes
`define MASK_NONE          8'h00
`define MASK_FULL          8'hFF
`define MASK_RETRY         8'hC0
`define MASK_CARD          8'h80
`define MASK_DEVCTL        8'h6F
`define MASK_DIAG          8'h1F
`define MASK_SOCK3         8'h08
`define MASK_MAXLAT        8'hF0
`define MASK_MINGNT        8'h0F
`define MASK_LINKENH       8'h86
`define MASK_HCC2          8'h80
`define DEVCTL_MUST_ZERO   8'h01
`define OHCI_INDICATOR     8'h02
`define OHCI_BYTE_COUNT    8'h17
`define NO_MINIROM         8'h00

// ==========================================================================
// Configuration byte slots
`define SLOT_ROUTE3        5'h00
`define SLOT_RETRY         5'h01
`define SLOT_CARD          5'h02
`define SLOT_DEVCTL        5'h03
`define SLOT_DIAG          5'h04
`define SLOT_SOCK3         5'h05
`define SLOT_MINGNT        5'h06
`define SLOT_MAXLAT        5'h07
`define SLOT_SVID0         5'h08
`define SLOT_SVID1         5'h09
`define SLOT_SSID0         5'h0A
`define SLOT_SSID1         5'h0B
`define SLOT_LINKENH       5'h0C
`define SLOT_HCC2          5'h0D
`define SLOT_MINIROM       5'h0E
`define SLOT_UID0          5'h0F
`define SLOT_UID1          5'h10
`define SLOT_NONE          5'h1F
`define NUM_SLOTS          17

// ==========================================================================
// Avalon register byte offsets and control bit position
`define REG_CTRL           6'h00
`define REG_STATUS         6'h04
`define REG_ROUTE          6'h08
`define REG_DIAG           6'h0C
`define REG_SOCK           6'h10
`define REG_SUBSYS         6'h14
`define REG_HCCTRL         6'h18
`define REG_LINK           6'h1C
`define CTRL_START_BIT     0
`define RESET_BYTE         8'h00

`endif

// ===== hw/loader_pkg.sv
// Types and shared decode functions for the configuration loader.
// Assumes loader_params.svh is on the include path.
package loader_pkg;
`include "loader_params.svh"

    typedef logic [4:0] slot_t;

    typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT} load_state_e;

    typedef struct packed {
        slot_t       slotA;
        logic [7:0]  maskA;
        slot_t       slotB;
        logic [7:0]  maskB;
        logic        shiftB;
        logic        chkInd;
        logic        chkCnt;
        logic        chkDev;
    } map_s;

    typedef struct packed {
        logic        miniRomPresent;
        logic        devBitErr;
        logic        countErr;
        logic        indicatorErr;
        logic        done;
        logic        busy;
    } status_s;

    // Only masked bits change; the rest keep their value
    function automatic logic [7:0] mergeBits(input logic [7:0] oldVal,
                                             input logic [7:0] newVal,
                                             input logic [7:0] mask);
        mergeBits = (oldVal & ~mask) | (newVal & mask);
    endfunction : mergeBits

    // Slot held in each byte lane of a register word, lane 0 lowest
    function automatic logic [19:0] lanesOf(input logic [5:0] addr);
        case (addr)
            `REG_ROUTE:  lanesOf = {`SLOT_DEVCTL, `SLOT_CARD,
                                    `SLOT_RETRY, `SLOT_ROUTE3};
            `REG_DIAG:   lanesOf = {`SLOT_MINIROM, `SLOT_MAXLAT,
                                    `SLOT_MINGNT, `SLOT_DIAG};
            `REG_SOCK:   lanesOf = {`SLOT_SOCK3, `SLOT_NONE,
                                    `SLOT_NONE, `SLOT_NONE};
            `REG_SUBSYS: lanesOf = {`SLOT_SSID1, `SLOT_SSID0,
                                    `SLOT_SVID1, `SLOT_SVID0};
            `REG_HCCTRL: lanesOf = {`SLOT_NONE, `SLOT_HCC2,
                                    `SLOT_NONE, `SLOT_NONE};
            `REG_LINK:   lanesOf = {`SLOT_UID1, `SLOT_UID0,
                                    `SLOT_NONE, `SLOT_LINKENH};
            default:     lanesOf = {4{`SLOT_NONE}};
        endcase
    endfunction : lanesOf

endpackage : loader_pkg

// ===== hw/rom_byte_fetch.sv
// Single-byte fetch from the serial ROM reader port.
// Assumes the reader answers each held request with one romValid pulse.
`timescale 1ns/1ps
module rom_byte_fetch
    import loader_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        fetchGo,
    input  wire logic [7:0]  fetchAddr,
    input  wire logic [7:0]  romData,
    input  wire logic        romValid,
    output logic             romReadReq,
    output logic [7:0]       romAddr,
    output logic [7:0]       byteOut,
    output logic             byteValid
);

    // ======================================================================
    // Request held until the reader answers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            romReadReq <= 1'b0;
            romAddr    <= `RESET_BYTE;
        end
        else if (fetchGo)
        begin
            romReadReq <= 1'b1;
            romAddr    <= fetchAddr;
        end
        else if (romReadReq && romValid)
            romReadReq <= 1'b0;
    end

    // ======================================================================
    // Captured byte, presented for one cycle
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            byteValid <= 1'b0;
            byteOut   <= `RESET_BYTE;
        end
        else
        begin
            byteValid <= romReadReq && romValid;
            if (romReadReq && romValid)
                byteOut <= romData;
        end
    end

endmodule : rom_byte_fetch

// ===== hw/rom_map_decode.sv
// Maps a serial ROM offset onto configuration slots, bit masks and checks.
// Purely combinational; unlisted offsets load nothing.
`timescale 1ns/1ps
module rom_map_decode
    import loader_pkg::*;
(
    input  wire logic [7:0]  romOffset,
    output map_s             entry
);

    always_comb
    begin
        entry = '{slotA: `SLOT_NONE, maskA: `MASK_NONE,
                  slotB: `SLOT_NONE, maskB: `MASK_NONE,
                  shiftB: 1'b0, chkInd: 1'b0, chkCnt: 1'b0, chkDev: 1'b0};
        case (romOffset)
            `ROM_ROUTE3:
            begin
                entry.slotA = `SLOT_ROUTE3;
                entry.maskA = `MASK_FULL;
            end
            `ROM_RETRY:
            begin
                entry.slotA = `SLOT_RETRY;
                entry.maskA = `MASK_RETRY;
            end
            `ROM_CARD:
            begin
                entry.slotA = `SLOT_CARD;
                entry.maskA = `MASK_CARD;
            end
            `ROM_DEVCTL:
            begin
                entry.slotA  = `SLOT_DEVCTL;
                entry.maskA  = `MASK_DEVCTL;
                entry.chkDev = 1'b1;
            end
            `ROM_DIAG:
            begin
                entry.slotA = `SLOT_DIAG;
                entry.maskA = `MASK_DIAG;
            end
            `ROM_SOCK:
            begin
                entry.slotA = `SLOT_SOCK3;
                entry.maskA = `MASK_SOCK3;
            end
            `ROM_OHCI_IND: entry.chkInd = 1'b1;
            `ROM_OHCI_CNT: entry.chkCnt = 1'b1;
            `ROM_LATGNT:
            begin
                entry.slotA = `SLOT_MAXLAT;
                entry.maskA = `MASK_MAXLAT;
                entry.slotB = `SLOT_MINGNT;
                entry.maskB = `MASK_MINGNT;
            end
            `ROM_SVID0:
            begin
                entry.slotA = `SLOT_SVID0;
                entry.maskA = `MASK_FULL;
            end
            `ROM_SVID1:
            begin
                entry.slotA = `SLOT_SVID1;
                entry.maskA = `MASK_FULL;
            end
            `ROM_SSID0:
            begin
                entry.slotA = `SLOT_SSID0;
                entry.maskA = `MASK_FULL;
            end
            `ROM_SSID1:
            begin
                entry.slotA = `SLOT_SSID1;
                entry.maskA = `MASK_FULL;
            end
            `ROM_LINK:
            begin
                entry.slotA  = `SLOT_LINKENH;
                entry.maskA  = `MASK_LINKENH;
                entry.slotB  = `SLOT_HCC2;
                entry.maskB  = `MASK_HCC2;
                entry.shiftB = 1'b1;
            end
            `ROM_MINIROM:
            begin
                entry.slotA = `SLOT_MINIROM;
                entry.maskA = `MASK_FULL;
            end
            `ROM_UID0:
            begin
                entry.slotA = `SLOT_UID0;
                entry.maskA = `MASK_FULL;
            end
            `ROM_UID1:
            begin
                entry.slotA = `SLOT_UID1;
                entry.maskA = `MASK_FULL;
            end
            default:
            begin
                entry.slotA = `SLOT_NONE;
            end
        endcase
    end

endmodule : rom_map_decode

// ===== hw/serial_rom_config_loader_mid.sv
// Configuration loader for serial ROM offsets 14h..2Ch, with an Avalon-MM
// slave for control, status and the loaded configuration bytes.
// Assumes a serial ROM reader behind romReadReq/romAddr/romValid.
//
// Functional notes
// - ROM byte 14h is copied whole into routing byte 3 (config 8Fh).
// - ROM byte 15h loads only bits 7 and 6 of retry status (config 90h).
// - ROM byte 16h loads only bit 7 of card control (config 91h).
// - ROM byte 17h loads device control bits 6,5,3..0; ROM bit 0 must be 0.
// - ROM byte 18h loads diagnostic bits 4..0 (config 93h).
// - ROM byte 22h must be the function indicator 02h for the 1394 section.
// - ROM byte 23h must give the 1394 section length 17h.
// - ROM bytes 25h..28h load subsystem vendor and subsystem ID, 2Ch..2Fh.
// - ROM byte 29h bits 7,2,1 go to link enhancement, bit 6 to bit 23.
// - ROM byte 2Ah is the auxiliary ROM pointer; 00h means none present.
// - Each function section opens with an indicator byte then a count.
`timescale 1ns/1ps
module serial_rom_config_loader_mid
    import loader_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             romReadReq,
    output logic [7:0]       romAddr,
    input  wire logic [7:0]  romData,
    input  wire logic        romValid
);

    // ======================================================================
    // Declarations
    load_state_e state_ff;
    load_state_e nxt_state;
    logic [7:0]  romOff_ff;
    logic        startPending_ff;
    status_s     status_ff;
    logic [7:0]  slots_ff [`NUM_SLOTS];
    logic        fetchGo;
    logic [7:0]  fetchByte;
    logic        fetchValid;
    map_s        mapEntry;
    logic        busReq;
    logic        busTaken;
    logic        launch;
    logic        applyNow;
    logic        lastByte;
    logic        swStart;
    logic [7:0]  dataB;
    logic [19:0] busLanes;

    // ======================================================================
    // Submodules
    rom_byte_fetch u_fetch (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .fetchGo    (fetchGo),
        .fetchAddr  (romOff_ff),
        .romData    (romData),
        .romValid   (romValid),
        .romReadReq (romReadReq),
        .romAddr    (romAddr),
        .byteOut    (fetchByte),
        .byteValid  (fetchValid)
    );

    rom_map_decode u_decode (
        .romOffset  (romOff_ff),
        .entry      (mapEntry)
    );

    // ======================================================================
    // Control terms
    assign busReq   = avs_read || avs_write;
    assign busTaken = busReq && !avs_waitrequest;
    assign launch   = (state_ff == ST_IDLE) && startPending_ff;
    assign fetchGo  = (state_ff == ST_ISSUE);
    assign applyNow = (state_ff == ST_WAIT) && fetchValid;
    assign lastByte = (romOff_ff == `ROM_LAST);
    assign busLanes = lanesOf(avs_address);
    assign swStart  = avs_write && busTaken && (avs_address == `REG_CTRL)
                      && avs_byteenable[0]
                      && avs_writedata[`CTRL_START_BIT];
    // Second target of 29h sits one bit higher (ROM bit 6 -> bit 23)
    assign dataB    = mapEntry.shiftB ? {fetchByte[6:0], 1'b0} : fetchByte;

    // ======================================================================
    // Load sequencer
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:  if (startPending_ff) nxt_state = ST_ISSUE;
            ST_ISSUE: nxt_state = ST_WAIT;
            ST_WAIT:
            begin
                if (fetchValid)
                    nxt_state = lastByte ? ST_IDLE : ST_ISSUE;
            end
            default:  nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            romOff_ff <= `ROM_FIRST;
        else if (launch)
            romOff_ff <= `ROM_FIRST;
        else if (applyNow && !lastByte)
            romOff_ff <= romOff_ff + 8'h01;
    end

    // Loads once after reset; software may request a reload at any time, started once idle
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            startPending_ff <= 1'b1;
        else if (swStart)
            startPending_ff <= 1'b1;
        else if (launch)
            startPending_ff <= 1'b0;
    end

    // ======================================================================
    // Status; errors are sticky until the next load starts
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            status_ff <= '0;
        else
        begin
            status_ff.busy           <= (nxt_state != ST_IDLE);
            status_ff.miniRomPresent <=
                (slots_ff[`SLOT_MINIROM] != `NO_MINIROM);
            if (launch)
            begin
                status_ff.done         <= 1'b0;
                status_ff.indicatorErr <= 1'b0;
                status_ff.countErr     <= 1'b0;
                status_ff.devBitErr    <= 1'b0;
            end
            else if (applyNow)
            begin
                if (lastByte)
                    status_ff.done <= 1'b1;
                // Section marker checked in indicator-then-count order
                if (mapEntry.chkInd && fetchByte != `OHCI_INDICATOR)
                    status_ff.indicatorErr <= 1'b1;
                if (mapEntry.chkCnt && fetchByte != `OHCI_BYTE_COUNT)
                    status_ff.countErr <= 1'b1;
                if (mapEntry.chkDev && |(fetchByte & `DEVCTL_MUST_ZERO))
                    status_ff.devBitErr <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Configuration bytes: loader merge, software writes when idle
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < `NUM_SLOTS; i++)
                slots_ff[i] <= `RESET_BYTE;
        end
        else if (applyNow)
        begin
            if (mapEntry.slotA != `SLOT_NONE)
                slots_ff[mapEntry.slotA] <=
                    mergeBits(slots_ff[mapEntry.slotA], fetchByte,
                              mapEntry.maskA);
            if (mapEntry.slotB != `SLOT_NONE)
                slots_ff[mapEntry.slotB] <=
                    mergeBits(slots_ff[mapEntry.slotB], dataB,
                              mapEntry.maskB);
        end
        else if (avs_write && busTaken && state_ff == ST_IDLE)
        begin
            // Writes during a load are dropped so the ROM image wins
            for (int l = 0; l < 4; l++)
            begin
                if (avs_byteenable[l] &&
                    busLanes[l*5 +: 5] != `SLOT_NONE)
                    slots_ff[busLanes[l*5 +: 5]] <=
                        avs_writedata[l*8 +: 8];
            end
        end
    end

    // ======================================================================
    // Avalon slave: one wait cycle, answer on the second edge
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !(busReq && avs_waitrequest);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && avs_waitrequest)
        begin
            case (avs_address)
                `REG_CTRL:   avs_readdata <= {31'h0000_0000,
                                              startPending_ff};
                `REG_STATUS: avs_readdata <= {26'h000_0000, status_ff};
                default:
                begin
                    for (int l = 0; l < 4; l++)
                    begin
                        if (busLanes[l*5 +: 5] == `SLOT_NONE)
                            avs_readdata[l*8 +: 8] <= `RESET_BYTE;
                        else
                            avs_readdata[l*8 +: 8] <=
                                slots_ff[busLanes[l*5 +: 5]];
                    end
                end
            endcase
        end
    end

endmodule : serial_rom_config_loader_mid

// ===== verif/loader_mid_asserts.sv
// Port-level assertions for the configuration loader.
// Bound to serial_rom_config_loader_mid; one clock domain.
`timescale 1ns/1ps
module loader_mid_asserts (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        romReadReq,
    input wire logic [7:0]  romAddr,
    input wire logic [7:0]  romData,
    input wire logic        romValid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ==========================================================
    // Register bus
    AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=>
        avs_waitrequest && !romReadReq && avs_readdata == 32'h0)
        else $error("outputs not quiet after reset");
    AST_ONE_WAIT: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    AST_WAIT_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_WAIT_IDLE: assert property (!(avs_read || avs_write) &&
        avs_waitrequest |=> avs_waitrequest)
        else $error("answer without a request");

    // ==========================================================
    // Serial ROM walk
    AST_ROM_START: assert property ($fell(reset) |->
        ##[1:4] (romReadReq && romAddr == 8'h14))
        else $error("load did not start at offset 14h");
    AST_ROM_HOLD: assert property (romReadReq && !romValid |=>
        romReadReq && $stable(romAddr))
        else $error("ROM request dropped or moved before answer");
    AST_ROM_STEP: assert property (romReadReq && romValid &&
        romAddr != 8'h2C |-> ##3 (romReadReq &&
        romAddr == $past(romAddr, 3) + 8'h01))
        else $error("next ROM offset wrong or late");
    AST_ROM_STOP: assert property (romReadReq && romValid &&
        romAddr == 8'h2C |=> (!romReadReq) [*3])
        else $error("ROM reads continue past 2Ch");
    AST_ROM_BOUNDS: assert property (romReadReq |->
        romAddr inside {[8'h14:8'h2C]})
        else $error("ROM offset outside the mapped range");

    CVR_LAST_BYTE: cover property (romValid && romAddr == 8'h2C);
    CVR_ROM_STALL: cover property (romReadReq && !romValid [*3]);
    CVR_WRITE: cover property (avs_write && !avs_waitrequest);
endmodule : loader_mid_asserts

bind serial_rom_config_loader_mid loader_mid_asserts i_asserts (
    .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .romReadReq(romReadReq), .romAddr(romAddr), .romData(romData),
    .romValid(romValid));

// ===== verif/serial_rom_model.sv
// Behavioural serial ROM reader: answers a held request after lag cycles.
// Image is written by the bench through the mem array.
`timescale 1ns/1ps
module serial_rom_model (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [3:0] lag,
    input  wire logic       romReadReq,
    input  wire logic [7:0] romAddr,
    output logic [7:0]      romData,
    output logic            romValid
);
    logic [7:0] mem [0:255];
    logic [3:0] waitCnt;

    // Data is scrambled outside the valid pulse so stale bytes never pass
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            romValid <= 1'b0;
            waitCnt  <= 4'h0;
            romData  <= 8'h5A;
        end
        else if (!romValid && romReadReq && waitCnt >= lag)
        begin
            romValid <= 1'b1;
            romData  <= mem[romAddr];
            waitCnt  <= 4'h0;
        end
        else
        begin
            romValid <= 1'b0;
            romData  <= ~romData;
            waitCnt  <= (romReadReq && !romValid) ? waitCnt + 4'h1 : 4'h0;
        end
    end
endmodule : serial_rom_model

// ===== verif/tb_serial_rom_config_loader_mid.sv
// Self-checking bench: loads two ROM images and checks the register view.
// Assumes the ROM model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_serial_rom_config_loader_mid;
    logic        sys_clk, reset, avs_read, avs_write, romReadReq, romValid;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        avs_waitrequest;
    logic [7:0]  romAddr, romData;
    logic [3:0]  lag, be;
    int          fail_count, checked;
    logic [5:0]  regA [6] = '{6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C};
    logic [31:0] laneM [6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFF000000,
                               32'hFFFFFFFF, 32'h00FF0000, 32'hFFFF00FF};

    serial_rom_config_loader_mid i_dut (.sys_clk(sys_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .romReadReq(romReadReq),
        .romAddr(romAddr), .romData(romData), .romValid(romValid));
    serial_rom_model i_rom (.sys_clk(sys_clk), .reset(reset), .lag(lag),
        .romReadReq(romReadReq), .romAddr(romAddr), .romData(romData),
        .romValid(romValid));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Closing, comparison and bus tasks
    task automatic report_and_stop;
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
        begin
            fail_count++;
            $display("BAD %0t bus answer missing", $time);
            report_and_stop();
        end
    endtask : bus

    task automatic waitSt(input int b);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, 6'h04, 32'h0);
            n++;
        end
        while (q[b] !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            fail_count++;
            $display("BAD %0t status bit never set", $time);
            report_and_stop();
        end
    endtask : waitSt

    // Markers and the device control bit are right only when ok is set
    task automatic img(input logic [7:0] s, input logic ok);
        for (int a = 8'h14; a <= 8'h2C; a++)
            i_rom.mem[a] = 8'(a) * 8'h1D ^ s;
        i_rom.mem[8'h17][0] = !ok;
        i_rom.mem[8'h22] = ok ? 8'h02 : 8'h03;
        i_rom.mem[8'h23] = ok ? 8'h17 : 8'h16;
        i_rom.mem[8'h2A] = ok ? 8'h40 : 8'h00;
    endtask : img

    function automatic logic [7:0] mg(input logic [7:0] o, n, m);
        mg = (o & ~m) | (n & m);
    endfunction : mg

    function automatic logic [31:0] expReg(input int i, input logic [31:0] o);
        case (i)
            0: expReg = {mg(o[31:24], i_rom.mem[8'h17], 8'h6F),
                mg(o[23:16], i_rom.mem[8'h16], 8'h80),
                mg(o[15:8], i_rom.mem[8'h15], 8'hC0), i_rom.mem[8'h14]};
            1: expReg = {i_rom.mem[8'h2A],
                mg(o[23:16], i_rom.mem[8'h24], 8'hF0),
                mg(o[15:8], i_rom.mem[8'h24], 8'h0F),
                mg(o[7:0], i_rom.mem[8'h18], 8'h1F)};
            2: expReg = {mg(o[31:24], i_rom.mem[8'h1C], 8'h08), 24'h0};
            3: expReg = {i_rom.mem[8'h28], i_rom.mem[8'h27],
                i_rom.mem[8'h26], i_rom.mem[8'h25]};
            4: expReg = {8'h00, mg(o[23:16], {i_rom.mem[8'h29][6], 7'h0},
                8'h80), 16'h0};
            default: expReg = {i_rom.mem[8'h2C], i_rom.mem[8'h2B], 8'h00,
                mg(o[7:0], i_rom.mem[8'h29], 8'h86)};
        endcase
    endfunction : expReg

    // ==========================================================
    // Main sequence
    initial
    begin
        fail_count = 0;
        checked = 0;
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        lag = 4'h0;
        be = 4'hF;
        img(8'hA5, 1'b1);
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        waitSt(1);
        chk(q, 32'h00000022);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, regA[i], 32'h0);
            chk(q, expReg(i, 32'h0));
        end
        bus(1'b1, 6'h20, 32'hFFFFFFFF);
        bus(1'b0, 6'h20, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, regA[i], 32'hFFFFFFFF);
            bus(1'b0, regA[i], 32'h0);
            chk(q, laneM[i]);
        end
        be <= 4'h2;
        bus(1'b1, 6'h14, 32'h0);
        be <= 4'hF;
        bus(1'b0, 6'h14, 32'h0);
        chk(q, 32'hFFFF00FF);
        // Slow ROM and wrong markers; a write during the load must drop
        img(8'h3C, 1'b0);
        lag <= 4'h5;
        bus(1'b1, 6'h00, 32'h1);
        waitSt(0);
        bus(1'b1, 6'h08, 32'h0);
        waitSt(1);
        chk(q, 32'h0000001E);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, regA[i], 32'h0);
            chk(q, expReg(i, laneM[i]));
        end
        report_and_stop();
    end
endmodule : tb_serial_rom_config_loader_mid
